// ==== rtl/stp_pkg.sv ====
// Package of the shared timer prescaler: register map, fields, constants.
// Assumes a single 100 MHz system clock and an AHB-Lite register port.
package stp_pkg;

	// ****************************************************************
	// Register map and fields.
	// ****************************************************************
	localparam logic [31:0] GTC_OFFSET = 32'h0000_0023;
	localparam logic [31:0] GTC_ADDR = GTC_OFFSET << 2;
	localparam logic [31:0] TSEL_ADDR = 32'h0000_0100;
	localparam logic [31:0] ASTAT_ADDR = 32'h0000_0104;
	localparam logic [7:0] GTC_RESET = 8'h00;
	localparam int HOLD_BIT = 7;
	localparam int ASYNC_BIT = 1;
	localparam int SYNC_BIT = 0;
	localparam int NUM_TIMERS = 5;
	localparam int SEL_W = 3;
	localparam logic [14:0] TSEL_RESET = 15'h0000;

	// ****************************************************************
	// Clock source select encodings.
	// ****************************************************************
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_SYS = 3'h1;
	localparam logic [2:0] CS_DIV8 = 3'h2;
	localparam logic [2:0] CS_DIV64 = 3'h3;
	localparam logic [2:0] CS_DIV256 = 3'h4;
	localparam logic [2:0] CS_DIV1024 = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;

	// ****************************************************************
	// Divider taps: a tap fires when the low bits of the counter are all
	// ones, giving one pulse every N system cycles.
	// ****************************************************************
	localparam int DIV_W = 10;
	localparam logic [9:0] TAP8_MASK = 10'h007;
	localparam logic [9:0] TAP64_MASK = 10'h03F;
	localparam logic [9:0] TAP256_MASK = 10'h0FF;
	localparam logic [9:0] TAP1024_MASK = 10'h3FF;

	typedef enum logic [1:0] {
		BUS_IDLE,
		BUS_DATA
	} stp_bus_t;

	typedef struct packed {
		logic [31:0] haddr;
		logic hwrite;
	} stp_req_t;

	typedef struct packed {
		logic [9:0] div;
		logic [7:0] gtc;
		logic [14:0] tsel;
		logic async_busy;
		logic [2:0] pin_sync;
		logic pin_stable;
		logic pin_prev;
		logic [4:0] tick;
		logic async_rst;
		logic sync_rst;
		stp_bus_t bus;
		stp_req_t req;
		logic [31:0] hrdata;
	} stp_state_t;

endpackage

// ==== rtl/stp_top.sv ====
// Shared timer prescaler, clock-source select and external pin sampling.
// Assumes an AHB-Lite master on the system clock and timers that take
// one-cycle tick enables in the same clock domain.
//
// Behaviour
// - Select one gives undivided system clock tick.
// - Taps divide by 8, 64, 256, 1024.
// - Divider runs free of any select.
// - Divider reset restarts only timers on prescaled selects (two to five).
// - Count pin sampled once per system cycle.
// - Select seven rising, six falling pin edges.
// - Pin edge reaches timer tick in five cycles, counter in six.
// - Pin ticks bypass the divider entirely.
// - Hold bit keeps both reset bits asserted.
// - Clearing hold clears both reset bits.
// - Async reset bit self-clears unless held.
// - Sync reset bit self-clears unless held.
// - Reserved bits read zero, ignore writes.
`timescale 1ns/10ps

module stp_top (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic external_count_pin,
	input wire logic async_reset_done,
	input wire logic async_mode,
	output logic [stp_pkg::NUM_TIMERS-1:0] timer_tick,
	output logic sync_divider_rst,
	output logic async_divider_rst
);
	import stp_pkg::*;

	stp_state_t s_q;
	stp_state_t s_d;

	// ****************************************************************
	// Tick selection for one timer.
	// ****************************************************************
	function automatic logic pick_tick(input logic [2:0] sel,
			input logic [9:0] div, input logic rise, input logic fall,
			input logic hold_rst);
		logic t;
		t = 1'b0;
		case (sel)
			CS_STOP: t = 1'b0;
			CS_SYS: t = 1'b1;
			CS_DIV8: t = (div & TAP8_MASK) == TAP8_MASK;
			CS_DIV64: t = (div & TAP64_MASK) == TAP64_MASK;
			CS_DIV256: t = (div & TAP256_MASK) == TAP256_MASK;
			CS_DIV1024: t = div == TAP1024_MASK;
			CS_EXT_FALL: t = fall;
			CS_EXT_RISE: t = rise;
			default: t = 1'b0;
		endcase
		// Only prescaled ticks halt while the divider is held in reset.
		// The direct system clock and the pin path bypass the divider.
		if (hold_rst && sel >= CS_DIV8 && sel <= CS_DIV1024) begin
			t = 1'b0;
		end
		return t;
	endfunction

	logic rise;
	logic fall;
	logic wr_gtc;
	logic wr_tsel;
	logic [7:0] wdat;
	logic [31:0] rd;
	logic hold;

	// ****************************************************************
	// Next-state logic.
	// ****************************************************************
	always_comb begin
		s_d = s_q;
		rise = 1'b0;
		fall = 1'b0;
		wr_gtc = 1'b0;
		wr_tsel = 1'b0;
		wdat = hwdata[7:0];
		rd = 32'h0000_0000;
		hold = 1'b0;

		// Count pin through three sampling stages, once per cycle.
		s_d.pin_sync = {s_q.pin_sync[1:0], external_count_pin};
		if (s_q.pin_sync[2] == s_q.pin_sync[1]) begin
			s_d.pin_stable = s_q.pin_sync[2];
		end
		s_d.pin_prev = s_q.pin_stable;
		rise = s_q.pin_stable && !s_q.pin_prev;
		fall = !s_q.pin_stable && s_q.pin_prev;

		// Free running divider, cleared only by the shared reset.
		if (s_q.sync_rst) begin
			s_d.div = 10'h000;
		end else begin
			s_d.div = s_q.div + 10'h001;
		end

		for (int i = 0; i < NUM_TIMERS; i++) begin
			s_d.tick[i] = pick_tick(s_q.tsel[i*SEL_W +: SEL_W], s_q.div,
				rise, fall, s_q.sync_rst);
		end

		// Bus slave: one address phase, zero-wait data phase.
		s_d.bus = BUS_IDLE;
		if (hsel && htrans[1] && hready) begin
			s_d.bus = BUS_DATA;
			s_d.req.haddr = haddr;
			s_d.req.hwrite = hwrite;
		end
		wr_gtc = s_q.bus == BUS_DATA && s_q.req.hwrite
			&& s_q.req.haddr == GTC_ADDR;
		wr_tsel = s_q.bus == BUS_DATA && s_q.req.hwrite
			&& s_q.req.haddr == TSEL_ADDR;

		// Control register: hold bit and the two divider reset bits.
		hold = s_q.gtc[HOLD_BIT];
		if (wr_gtc) begin
			hold = wdat[HOLD_BIT];
			s_d.gtc = 8'h00;
			s_d.gtc[HOLD_BIT] = wdat[HOLD_BIT];
			s_d.gtc[SYNC_BIT] = wdat[SYNC_BIT];
			s_d.gtc[ASYNC_BIT] = wdat[ASYNC_BIT];
			if (!wdat[HOLD_BIT]) begin
				s_d.gtc[SYNC_BIT] = 1'b0;
				s_d.gtc[ASYNC_BIT] = wdat[ASYNC_BIT] && async_mode;
			end
			s_d.async_busy = wdat[ASYNC_BIT] && async_mode;
		end else if (!hold) begin
			s_d.gtc[SYNC_BIT] = 1'b0;
			if (!s_q.async_busy || async_reset_done) begin
				s_d.gtc[ASYNC_BIT] = 1'b0;
				s_d.async_busy = 1'b0;
			end
		end

		// Reset signals follow the written value for that cycle.
		s_d.sync_rst = (wr_gtc && wdat[SYNC_BIT])
			|| (!wr_gtc && hold && s_q.gtc[SYNC_BIT]);
		s_d.async_rst = (wr_gtc && wdat[ASYNC_BIT])
			|| (!wr_gtc && ((hold && s_q.gtc[ASYNC_BIT])
			|| (s_q.async_busy && !async_reset_done)));

		if (wr_tsel) begin
			s_d.tsel = hwdata[14:0];
		end

		// Read data for the next data phase.
		case (haddr)
			GTC_ADDR: rd = {24'h000000, s_d.gtc};
			TSEL_ADDR: rd = {17'h00000, s_d.tsel};
			ASTAT_ADDR: rd = {30'h00000000, s_d.async_busy,
				s_d.pin_stable};
			default: rd = 32'h0000_0000;
		endcase
		if (hsel && htrans[1] && hready && !hwrite) begin
			s_d.hrdata = rd;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			s_q <= '{div: 10'h000, gtc: GTC_RESET, tsel: TSEL_RESET,
				async_busy: 1'b0, pin_sync: 3'h0, pin_stable: 1'b0,
				pin_prev: 1'b0, tick: 5'h00, async_rst: 1'b0,
				sync_rst: 1'b0, bus: BUS_IDLE,
				req: '{haddr: 32'h0000_0000, hwrite: 1'b0},
				hrdata: 32'h0000_0000};
		end else begin
			s_q <= s_d;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = s_q.hrdata;
	assign timer_tick = s_q.tick;
	assign sync_divider_rst = s_q.sync_rst;
	assign async_divider_rst = s_q.async_rst;

endmodule

// ==== verification/stp_checker.sv ====
// Port checker of the shared timer prescaler.
// Assumes it is bound to stp_top and sees only its ports.
`timescale 1ns/10ps
module stp_checker (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic async_mode,
	input wire logic async_reset_done,
	input wire logic sync_divider_rst,
	input wire logic async_divider_rst
);
	import stp_pkg::*;
	// ****************************************************************
	// Control register accesses seen on the bus.
	// ****************************************************************
	logic wr_q, rd_q, hold_q;
	wire take = hsel && htrans[1] && hready && haddr == GTC_ADDR;
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			hold_q <= 1'b0;
		end else begin
			wr_q <= take && hwrite;
			rd_q <= take && !hwrite;
			if (wr_q)
				hold_q <= hwdata[7];
		end
	end
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);
	sequence s_pulse;
		sync_divider_rst ##1 !sync_divider_rst;
	endsequence
	a_resp_okay: assert property (hreadyout && !hresp)
		else $error("bus answer not ready or not okay");
	a_sync_pulse: assert property (
		wr_q && hwdata[7:0] == 8'h01 |=> s_pulse)
		else $error("sync reset is not a single pulse");
	a_hold_sync: assert property (
		hold_q && !wr_q && sync_divider_rst |=> sync_divider_rst)
		else $error("sync reset dropped while held");
	a_hold_async: assert property (
		hold_q && !wr_q && async_divider_rst |=> async_divider_rst)
		else $error("async reset dropped while held");
	a_hold_clear: assert property (
		wr_q && hold_q && hwdata[7:0] == 8'h00
		|=> !sync_divider_rst && !async_divider_rst)
		else $error("resets not cleared with hold");
	a_async_wait: assert property (
		async_divider_rst && async_mode && !async_reset_done && !wr_q
		|=> async_divider_rst)
		else $error("async reset cleared before done");
	a_async_clear: assert property (
		async_divider_rst && !async_mode && !hold_q && !wr_q
		|=> !async_divider_rst)
		else $error("async reset did not self clear");
	a_rsvd_zero: assert property (
		rd_q |-> hrdata[6:2] == 5'h00)
		else $error("reserved bits read nonzero");
endmodule
bind stp_top stp_checker chk (.clock, .sys_rst, .hsel, .haddr, .htrans,
	.hwrite, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .async_mode,
	.async_reset_done, .sync_divider_rst, .async_divider_rst);

// ==== verification/stp_timers.sv ====
// Timer units fed by the shared prescaler ticks.
// Assumes one-cycle tick enables in the system clock domain.
`timescale 1ns/10ps
module stp_timers (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [stp_pkg::NUM_TIMERS-1:0] timer_tick,
	input wire logic async_divider_rst,
	output logic async_reset_done,
	output logic [stp_pkg::NUM_TIMERS-1:0][15:0] cnt
);
	import stp_pkg::*;
	logic [2:0] age_q;
	assign async_reset_done = age_q == 3'h7;
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			cnt <= '0;
			age_q <= 3'h0;
		end else begin
			for (int i = 0; i < NUM_TIMERS; i++)
				cnt[i] <= cnt[i] + 16'(timer_tick[i]);
			age_q <= !async_divider_rst ? 3'h0 : age_q + 3'(age_q != 3'h7);
		end
	end
endmodule

// ==== verification/tb_shared_timer_prescaler.sv ====
// Self-checking bench of the shared timer prescaler.
// Assumes stp_top, the timer model and the bound checker.
`timescale 1ns/10ps
module tb_shared_timer_prescaler;
	import stp_pkg::*;
	logic clock, sys_rst, hsel, hwrite, hreadyout, hresp;
	logic external_count_pin, async_mode, async_reset_done;
	logic sync_divider_rst, async_divider_rst;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, rv;
	logic [NUM_TIMERS-1:0] timer_tick;
	logic [NUM_TIMERS-1:0][15:0] cnt, snap;
	int fail_count, samples_checked;
	stp_top dut (.clock, .sys_rst, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
		.external_count_pin, .async_reset_done, .async_mode, .timer_tick,
		.sync_divider_rst, .async_divider_rst);
	stp_timers tmr (.clock, .sys_rst, .timer_tick, .async_divider_rst,
		.async_reset_done, .cnt);
	// ****************************************************************
	// Bus cycles and comparisons.
	// ****************************************************************
	task automatic chk(input string n, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [31:0] a, d);
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		do @(posedge clock); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clock); while (hreadyout !== 1'b1);
		rv = hrdata;
	endtask
	task automatic rd(input logic [31:0] a, e);
		bus(1'b0, a, 32'h0);
		chk("hrdata", e, rv);
	endtask
	task automatic win(input int n, input logic t,
		input logic [NUM_TIMERS-1:0][15:0] e);
		repeat (2) @(posedge clock);
		snap = cnt;
		for (int i = 1; i <= n; i++) begin
			@(posedge clock);
			if (t && i % 4 == 0 && i <= 80)
				external_count_pin <= !external_count_pin;
		end
		for (int i = 0; i < NUM_TIMERS; i++)
			chk("ticks", 32'(e[i]), 32'(cnt[i] - snap[i]));
	endtask
	task give_verdict;
		if (fail_count == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	initial begin
		repeat (20000) @(posedge clock);
		fail_count++;
		give_verdict;
	end
	initial begin
		sys_rst = 1'b1;
		{hsel, hwrite, external_count_pin, async_mode} = 4'h8;
		{htrans, hsize, haddr, hwdata} = {2'h0, 3'h2, 64'h0};
		repeat (5) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		rd(GTC_ADDR, 32'h0);
		rd(TSEL_ADDR, 32'h0);
		bus(1'b1, GTC_ADDR, 32'h7C);
		rd(GTC_ADDR, 32'h0);
		rd(32'h200, 32'h0);
		bus(1'b1, GTC_ADDR, 32'h01);
		rd(GTC_ADDR, 32'h0);
		bus(1'b1, TSEL_ADDR, 32'h58D1);
		win(2048, 1'b0, {16'h2, 16'h8, 16'h20, 16'h100, 16'h800});
		bus(1'b1, GTC_ADDR, 32'h83);
		rd(GTC_ADDR, 32'h83);
		chk("resets", 32'h3, {30'h0, sync_divider_rst, async_divider_rst});
		win(50, 1'b0, {16'h0, 16'h0, 16'h0, 16'h0, 16'h32});
		bus(1'b1, GTC_ADDR, 32'h00);
		rd(GTC_ADDR, 32'h0);
		chk("resets", 32'h0, {30'h0, sync_divider_rst, async_divider_rst});
		async_mode <= 1'b1;
		bus(1'b1, GTC_ADDR, 32'h02);
		rd(GTC_ADDR, 32'h02);
		repeat (12) @(posedge clock);
		rd(GTC_ADDR, 32'h0);
		async_mode <= 1'b0;
		bus(1'b1, TSEL_ADDR, 32'h1B8);
		win(96, 1'b1, {16'h0, 16'h0, 16'hA, 16'hA, 16'h0});
		give_verdict;
	end
endmodule
